/* File: core/lsc_map.svh */
// register offsets, field layout, reset values and timing counts of the link switch control
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH

`define LSC_OFS_SELECT     8'h00
`define LSC_OFS_RX_TERM    8'h04
`define LSC_OFS_RX_BOOST   8'h08
`define LSC_OFS_TX_SET     8'h0C
`define LSC_OFS_MODES      8'h10
`define LSC_OFS_STATUS     8'h14

`define LSC_IDX_SELECT     3'h0
`define LSC_IDX_RX_TERM    3'h1
`define LSC_IDX_RX_BOOST   3'h2
`define LSC_IDX_TX_SET     3'h3
`define LSC_IDX_MODES      3'h4
`define LSC_IDX_STATUS     3'h5
`define LSC_NUM_CFG        5

`define LSC_MASK_SELECT    16'h0003
`define LSC_MASK_RX_TERM   16'hFFFF
`define LSC_MASK_RX_BOOST  16'h00FF
`define LSC_MASK_TX_SET    16'h000F
`define LSC_MASK_MODES     16'h0001

`define LSC_TX_TERM_BIT    0
`define LSC_TX_CUR_BIT     1
`define LSC_TX_BOOST_LSB   2
`define LSC_ST_TAKEN_BIT   0
`define LSC_ST_ADDR_LSB    8

`define LSC_RST_CFG        16'h0000
`define LSC_ADDR_UPPER     4'h9

`define LSC_RESP_OKAY      2'h0
`define LSC_RESP_SLVERR    2'h2

`define LSC_CLK_PERIOD_NS  50
`define LSC_UPD_DELAY_NS   1000
`define LSC_UPD_CYCLES     ((`LSC_UPD_DELAY_NS + `LSC_CLK_PERIOD_NS - 1) / `LSC_CLK_PERIOD_NS)

`endif

/* File: core/lsc_pkg.sv */
// types shared by the link switch control logic
package lsc_pkg;

  typedef struct packed {
    logic [1:0] input_select;
    logic       boost_select;
    logic       output_term;
    logic       output_enable;
    logic       drive_current;
    logic [1:0] output_boost;
    logic [2:0] addr_low;
  } lsc_strap_t;

  typedef struct packed {
    logic [1:0]  link_select;
    logic [15:0] input_term_enable;
    logic [7:0]  input_boost_select;
    logic        output_term_enable;
    logic        drive_current_select;
    logic [1:0]  output_boost_level;
    logic        fast_output_enable;
  } lsc_ana_t;

endpackage

/* File: core/lsc_top.sv */
// configuration control of the four-input link switch, reached over AXI4-Lite
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "lsc_map.svh"

module lsc_top (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // strap pins
  input  wire lsc_pkg::lsc_strap_t strap_pins,
  // axi4-lite write address and data
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // analog path settings and mode
  output lsc_pkg::lsc_ana_t      analog_cfg,
  output logic                   serial_mode
);
  import lsc_pkg::*;

  localparam logic [7:0] UPD_CYCLES = 8'(`LSC_UPD_CYCLES);

  lsc_strap_t                     strap_meta;
  lsc_strap_t                     strap_sync;
  logic                           taken;
  logic [`LSC_NUM_CFG-1:0][15:0]  cfg;
  logic [`LSC_NUM_CFG-1:0][15:0]  applied;
  logic [`LSC_NUM_CFG-1:0][7:0]   win_cnt;
  logic                           aw_got;
  logic                           w_got;
  logic [7:0]                     wr_addr;
  logic [15:0]                    wr_data;
  logic [1:0]                     wr_strb;
  logic                           wr_commit;
  logic                           ar_hs;
  logic [2:0]                     wr_idx;
  logic                           wr_hit;
  logic [15:0]                    wr_be;
  logic [6:0]                     slave_addr;
  logic [15:0]                    status_word;

  // strap synchroniser
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      strap_meta <= '0;
      strap_sync <= '0;
    end else begin
      strap_meta <= strap_pins;
      strap_sync <= strap_meta;
    end
  end

  assign slave_addr  = {`LSC_ADDR_UPPER, strap_sync.addr_low};
  assign status_word = {1'b0, slave_addr, 7'h00, taken};
  assign wr_commit   = aw_got && w_got && !s_axi_bvalid;
  assign ar_hs       = s_axi_arvalid && s_axi_arready;
  assign wr_idx      = wr_addr[4:2];
  assign wr_hit      = (wr_addr[7:5] == 3'h0) && (wr_addr[1:0] == 2'h0)
                       && (wr_idx <= `LSC_IDX_STATUS);
  assign wr_be       = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  function automatic logic [15:0] lsc_mask(input logic [2:0] idx);
    case (idx)
      `LSC_IDX_SELECT:   lsc_mask = `LSC_MASK_SELECT;
      `LSC_IDX_RX_TERM:  lsc_mask = `LSC_MASK_RX_TERM;
      `LSC_IDX_RX_BOOST: lsc_mask = `LSC_MASK_RX_BOOST;
      `LSC_IDX_TX_SET:   lsc_mask = `LSC_MASK_TX_SET;
      `LSC_IDX_MODES:    lsc_mask = `LSC_MASK_MODES;
      default:           lsc_mask = 16'h0000;
    endcase
  endfunction

  // bus-access flag, cleared by reset alone
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      taken <= 1'b0;
    end else if (wr_commit || ar_hs) begin
      taken <= 1'b1;
    end
  end

  // configuration words: bus writes, else strap copy while strap control lasts
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= {`LSC_NUM_CFG{`LSC_RST_CFG}};
    end else if (wr_commit) begin
      if (wr_hit && wr_idx < `LSC_IDX_STATUS) begin
        cfg[wr_idx] <= ((cfg[wr_idx] & ~wr_be) | (wr_data & wr_be))
                       & lsc_mask(wr_idx);
      end
    end else if (!taken) begin
      // termination word is left alone: straps cannot reach it
      cfg[`LSC_IDX_SELECT]   <= {14'h0000, strap_sync.input_select};
      cfg[`LSC_IDX_RX_BOOST] <= {8'h00, {8{strap_sync.boost_select}}};
      cfg[`LSC_IDX_TX_SET]   <= {12'h000, strap_sync.output_boost,
                                 strap_sync.drive_current,
                                 strap_sync.output_term};
      cfg[`LSC_IDX_MODES]    <= {15'h0000, strap_sync.output_enable};
    end
  end

  // per-word update window
  genvar g;
  generate
    for (g = 0; g < `LSC_NUM_CFG; g++) begin : g_win
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          applied[g] <= `LSC_RST_CFG;
          win_cnt[g] <= 8'h00;
        end else if (win_cnt[g] == 8'h01) begin
          applied[g] <= cfg[g];
          win_cnt[g] <= 8'h00;
        end else if (win_cnt[g] != 8'h00) begin
          win_cnt[g] <= win_cnt[g] - 8'h01;
        end else if (cfg[g] != applied[g]) begin
          applied[g] <= cfg[g];
          win_cnt[g] <= UPD_CYCLES;
        end
      end

      chk_window_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
        (win_cnt[g] > 8'h01) |=> $stable(applied[g]))
        else $error("applied word changed inside its update window");

      chk_window_end: assert property (@(posedge sys_clk) disable iff (!rstn)
        (win_cnt[g] == 8'h01) |=> (applied[g] == $past(cfg[g])) && (win_cnt[g] == 8'h00))
        else $error("last written value not applied at window end");

      chk_window_open: assert property (@(posedge sys_clk) disable iff (!rstn)
        (win_cnt[g] == 8'h00 && cfg[g] != applied[g]) |=>
          (applied[g] == $past(cfg[g])) && (win_cnt[g] == UPD_CYCLES))
        else $error("idle word change not applied at once with a new window");

      chk_no_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
        (win_cnt[g] > 8'h01) |=> (win_cnt[g] == $past(win_cnt[g]) - 8'h01))
        else $error("update window restarted or stalled");
    end
  endgenerate

  // analog settings straight from the applied words
  assign analog_cfg.link_select          = applied[`LSC_IDX_SELECT][1:0];
  assign analog_cfg.input_term_enable    = applied[`LSC_IDX_RX_TERM];
  assign analog_cfg.input_boost_select   = applied[`LSC_IDX_RX_BOOST][7:0];
  assign analog_cfg.output_term_enable   = applied[`LSC_IDX_TX_SET][`LSC_TX_TERM_BIT];
  assign analog_cfg.drive_current_select = applied[`LSC_IDX_TX_SET][`LSC_TX_CUR_BIT];
  assign analog_cfg.output_boost_level   = applied[`LSC_IDX_TX_SET][`LSC_TX_BOOST_LSB +: 2];
  assign analog_cfg.fast_output_enable   = applied[`LSC_IDX_MODES][0];
  assign serial_mode                     = taken;

  // write address and data channels, taken in either order
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b0;
      aw_got        <= 1'b0;
      wr_addr       <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got        <= 1'b1;
      wr_addr       <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_got <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_wready <= 1'b0;
      w_got        <= 1'b0;
      wr_data      <= 16'h0000;
      wr_strb      <= 2'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got        <= 1'b1;
      wr_data      <= s_axi_wdata[15:0];
      wr_strb      <= s_axi_wstrb[1:0];
    end else if (wr_commit) begin
      w_got <= 1'b0;
    end else if (!w_got && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LSC_RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `LSC_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `LSC_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      if (s_axi_araddr[7:5] != 3'h0 || s_axi_araddr[1:0] != 2'h0
          || s_axi_araddr[4:2] > `LSC_IDX_STATUS) begin
        s_axi_rresp <= `LSC_RESP_SLVERR;
      end else if (s_axi_araddr[4:2] == `LSC_IDX_STATUS) begin
        s_axi_rdata <= {16'h0000, status_word};
      end else begin
        s_axi_rdata <= {16'h0000, cfg[s_axi_araddr[4:2]]};
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (!s_axi_arready) begin
      s_axi_arready <= 1'b1;
    end
  end

  // strap and flag checks
  chk_term_closed: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    !taken |-> (cfg[`LSC_IDX_RX_TERM] == 16'h0000))
    else $error("input termination set without a bus access");

  chk_term_bus_only: assert property (@(posedge sys_clk) disable iff (!rstn)
    !wr_commit |=> $stable(cfg[`LSC_IDX_RX_TERM]))
    else $error("input termination changed without a bus write");

  chk_strap_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!taken && !wr_commit && !ar_hs) |=>
      (cfg[`LSC_IDX_SELECT][1:0] == $past(strap_sync.input_select))
      && (cfg[`LSC_IDX_MODES][0] == $past(strap_sync.output_enable)))
    else $error("strap level not copied while strap control active");

  chk_strap_tx: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    (!taken && !wr_commit && !ar_hs) |=>
      (cfg[`LSC_IDX_TX_SET][3:0] == {$past(strap_sync.output_boost),
                                      $past(strap_sync.drive_current),
                                      $past(strap_sync.output_term)}))
    else $error("output straps not copied into transmitter settings");

  chk_boost_all: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!taken && !wr_commit && !ar_hs) |=>
      (cfg[`LSC_IDX_RX_BOOST][7:0] == {8{$past(strap_sync.boost_select)}}))
    else $error("boost strap did not set all eight channels");

  chk_strap_ignored: assert property (@(posedge sys_clk) disable iff (!rstn)
    (taken && !wr_commit) |=> $stable(cfg))
    else $error("configuration changed without a bus write");

  chk_taken_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
    taken |=> taken [*2])
    else $error("bus-access flag dropped without reset");

  chk_access_marks: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_commit || ar_hs) |=> taken && serial_mode)
    else $error("bus access did not end strap control");

  chk_status_ro: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_commit && wr_hit && wr_idx == `LSC_IDX_STATUS) |=> $stable(cfg) && taken)
    else $error("status write altered settings or the access flag");

  chk_field_masks: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    (cfg[`LSC_IDX_SELECT][15:2] == 14'h0000)
    && (cfg[`LSC_IDX_TX_SET][15:4] == 12'h000)
    && (cfg[`LSC_IDX_RX_BOOST][15:8] == 8'h00)
    && (cfg[`LSC_IDX_MODES][15:1] == 15'h0000))
    else $error("bits outside the defined fields were set");

  chk_addr_pattern: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ar_hs && s_axi_araddr == `LSC_OFS_STATUS) |=>
      (s_axi_rdata[14:8] == {`LSC_ADDR_UPPER, $past(strap_sync.addr_low)}))
    else $error("slave address read back wrong");

  // bus checks
  chk_write_resp: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_commit |=> s_axi_bvalid)
    else $error("write response not raised after commit");

  chk_bresp_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");

  chk_write_refused: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wr_commit && !wr_hit) |=> (s_axi_bresp == `LSC_RESP_SLVERR) && $stable(cfg))
    else $error("unmapped write not refused");

  chk_read_answer: assert property (@(posedge sys_clk) disable iff (!rstn)
    ar_hs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read address taken without an answer");

  chk_read_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held until taken");

  chk_read_refused: assert property (@(posedge sys_clk) disable iff (!rstn)
    (ar_hs && (s_axi_araddr[7:5] != 3'h0 || s_axi_araddr[1:0] != 2'h0)) |=>
      (s_axi_rresp == `LSC_RESP_SLVERR) && (s_axi_rdata == 32'h00000000))
    else $error("unmapped read not refused");

endmodule

/* File: verif/lsc_strap_model.sv */
// strap pin source facing the link switch control
`timescale 1ns/1ps
module lsc_strap_model (
  // clock
  input  wire logic          sys_clk,
  // strap pins
  output lsc_pkg::lsc_strap_t strap_pins
);
  import lsc_pkg::*;
  initial strap_pins = '0;
  // no external termination assumed, so enable needs internal one
  task automatic put(input lsc_strap_t s);
    lsc_strap_t t;
    t = s;
    t.output_enable = s.output_enable & s.output_term;
    @(posedge sys_clk);
    strap_pins <= t;
  endtask
endmodule

/* File: verif/tb_lsc_top.sv */
// self-checking bench of the link switch configuration control
`timescale 1ns/1ps
`include "lsc_map.svh"
module tb_lsc_top;
  import lsc_pkg::*;
  logic        sys_clk, rstn;
  lsc_strap_t  strap_pins;
  logic [7:0]  aw_a, ar_a;
  logic [31:0] w_d, r_d, rdat;
  logic [3:0]  w_s;
  logic [1:0]  b_r, r_rr, resp;
  logic        aw_v, aw_r, w_v, w_r, b_v, b_y, ar_v, ar_r, r_v, r_y, serial_mode;
  lsc_ana_t    analog_cfg, ex;
  int          err_total, cmp_count;
  localparam lsc_strap_t S1 = 11'h5DD;
  localparam lsc_strap_t S2 = 11'h22A;
  localparam lsc_strap_t S3 = 11'h7A7;

  lsc_strap_model i_lsc_strap_model (.sys_clk(sys_clk), .strap_pins(strap_pins));
  lsc_top i_lsc_top (
    .sys_clk(sys_clk), .rstn(rstn), .strap_pins(strap_pins),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
    .s_axi_bresp(b_r), .s_axi_bvalid(b_v), .s_axi_bready(b_y),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
    .s_axi_rdata(r_d), .s_axi_rresp(r_rr), .s_axi_rvalid(r_v), .s_axi_rready(r_y),
    .analog_cfg(analog_cfg), .serial_mode(serial_mode)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic lsc_ana_t fs(input lsc_strap_t s);
    lsc_ana_t a;
    a = '0;
    a.link_select = s.input_select;
    a.input_boost_select = {8{s.boost_select}};
    a.output_term_enable = s.output_term;
    a.drive_current_select = s.drive_current;
    a.output_boost_level = s.output_boost;
    a.fast_output_enable = s.output_enable & s.output_term;
    return a;
  endfunction

  task automatic rst;
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (30) @(posedge sys_clk);
  endtask

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit dn;
    dn = 0;
    @(posedge sys_clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_y <= 1'b1;
    for (int n = 0; n < 50 && !dn; n++) begin
      @(posedge sys_clk);
      if (aw_v && aw_r) begin
        aw_v <= 1'b0;
        aw_a <= ~a;
      end
      if (w_v && w_r) begin
        w_v <= 1'b0;
        w_d <= ~d;
      end
      if (b_v) begin
        dn = 1;
        resp = b_r;
        b_y <= 1'b0;
      end
    end
    chk("write_done", 1, dn);
    if (!dn) conclude();
  endtask

  task automatic rd(input logic [7:0] a);
    bit dn;
    dn = 0;
    @(posedge sys_clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_y <= 1'b1;
    for (int n = 0; n < 50 && !dn; n++) begin
      @(posedge sys_clk);
      if (ar_v && ar_r) begin
        ar_v <= 1'b0;
        ar_a <= ~a;
      end
      if (r_v) begin
        dn = 1;
        rdat = r_d;
        resp = r_rr;
        r_y <= 1'b0;
      end
    end
    chk("read_done", 1, dn);
    if (!dn) conclude();
  endtask

  task automatic t_straps;
    i_lsc_strap_model.put(S1);
    rst();
    chk("cfg_boot", fs(S1), analog_cfg);
    chk("mode_boot", 0, serial_mode);
    i_lsc_strap_model.put(S2);
    repeat (30) @(posedge sys_clk);
    chk("cfg_follow", fs(S2), analog_cfg);
    rd(`LSC_OFS_STATUS);
    chk("addr", {17'h0, 4'h9, S2.addr_low, 8'h00}, rdat & 32'h7F00);
    chk("mode_set", 1, serial_mode);
    i_lsc_strap_model.put(S1);
    repeat (30) @(posedge sys_clk);
    chk("cfg_locked", fs(S2), analog_cfg);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      wr(`LSC_OFS_SELECT, 32'(i));
      wr(`LSC_OFS_TX_SET, 32'(i * 4 + 1));
      repeat (25) @(posedge sys_clk);
      chk("select", 32'(i), analog_cfg.link_select);
      chk("pre_emph", 32'(i), analog_cfg.output_boost_level);
    end
    wr(`LSC_OFS_RX_TERM, 32'h1234A5C3);
    wr(`LSC_OFS_RX_BOOST, 32'h0000005A);
    wr(`LSC_OFS_TX_SET, 32'h0000000B);
    wr(`LSC_OFS_MODES, 32'h00000001);
    repeat (30) @(posedge sys_clk);
    ex = '0;
    ex.link_select = 2'h3;
    ex.input_term_enable = 16'hA5C3;
    ex.input_boost_select = 8'h5A;
    ex.output_term_enable = 1'b1;
    ex.drive_current_select = 1'b1;
    ex.output_boost_level = 2'h2;
    ex.fast_output_enable = 1'b1;
    chk("cfg_serial", ex, analog_cfg);
    rd(`LSC_OFS_RX_TERM);
    chk("term_back", 32'h0000A5C3, rdat);
    chk("rresp_ok", `LSC_RESP_OKAY, resp);
  endtask

  task automatic t_window;
    wr(`LSC_OFS_SELECT, 32'h0);
    wr(`LSC_OFS_SELECT, 32'h1);
    wr(`LSC_OFS_SELECT, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk("win_hold", 0, analog_cfg.link_select);
    repeat (13) @(posedge sys_clk);
    chk("win_last", 2, analog_cfg.link_select);
  endtask

  task automatic t_errors;
    wr(8'h40, 32'h00000001);
    chk("resp_far", `LSC_RESP_SLVERR, resp);
    wr(8'h02, 32'h00000001);
    chk("resp_unal", `LSC_RESP_SLVERR, resp);
    rd(8'h18);
    chk("rresp_far", `LSC_RESP_SLVERR, resp);
    chk("rdata_far", 0, rdat);
    wr(`LSC_OFS_STATUS, 32'h00000000);
    chk("resp_ro", `LSC_RESP_OKAY, resp);
    rd(`LSC_OFS_STATUS);
    chk("flag_kept", 1, rdat[0]);
    i_lsc_strap_model.put(S3);
    rst();
    chk("cfg_rerst", fs(S3), analog_cfg);
    chk("mode_rerst", 0, serial_mode);
  endtask

  initial begin
    rstn = 1'b0;
    {aw_a, ar_a, w_d, aw_v, w_v, b_y, ar_v, r_y} = '0;
    w_s = 4'hF;
    err_total = 0;
    cmp_count = 0;
    t_straps();
    t_regs();
    t_window();
    t_errors();
    conclude();
  end
endmodule
